// *** core/pmts_sequencer.sv ***
// Power-mode sequencer with low-power tamper detector
`timescale 1ns/1ps
`include "pmts_map.svh"
module pmts_sequencer
  import pmts_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        clk_en_in,
  input  wire logic [1:0]  mode_pins_in,
  input  wire logic        hw_reset_n_in,
  input  wire logic        sw_reset_in,
  input  wire logic [2:0]  phase_peak_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [15:0] reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic [15:0]      reg_rdata_out,
  output logic             reg_ack_out,
  output logic             irq_line_zero_n_out,
  output logic             irq_line_one_n_out,
  output logic [1:0]       power_mode_out,
  output logic             serial_port_en_out,
  output logic             serial_port_limited_out,
  output logic             port_lock_out,
  output logic             mav_run_out,
  output logic             mav_access_out,
  output logic             core_active_out,
  output logic [2:0]       tamper_threshold_select_out,
  output logic             regs_default_out
);
  localparam logic [31:0] TICK_CYCLES = 32'(`PMTS_TICK_CYCLES);

  // Two-flop pin synchronisers
  logic [1:0] mode_s1_ff, mode_s2_ff;
  logic       hwr_s1_ff, hwr_s2_ff;
  logic [2:0] peak_s1_ff, peak_s2_ff;
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      mode_s1_ff <= 2'h0;
      mode_s2_ff <= 2'h0;
      hwr_s1_ff  <= 1'b1;
      hwr_s2_ff  <= 1'b1;
      peak_s1_ff <= 3'h0;
      peak_s2_ff <= 3'h0;
    end else if (clk_en_in) begin
      mode_s1_ff <= mode_pins_in;
      mode_s2_ff <= mode_s1_ff;
      hwr_s1_ff  <= hw_reset_n_in;
      hwr_s2_ff  <= hwr_s1_ff;
      peak_s1_ff <= phase_peak_in;
      peak_s2_ff <= peak_s1_ff;
    end
  end

  pmts_mode_t  req_mode;
  pmts_state_t state_ff, nxt_state;
  logic [7:0]  level_ff, nxt_level;
  logic [7:0]  cfg_ff, nxt_cfg;
  logic        only_mode_ff, nxt_only_mode;
  logic        done_flag_ff, nxt_done_flag;
  logic        l0_ff, nxt_l0;
  logic        l1_ff, nxt_l1;
  logic        result_ff, nxt_result;
  logic [4:0]  swrst_cnt_ff, nxt_swrst_cnt;
  logic [31:0] tick_ff, nxt_tick;
  logic [5:0]  period_ff, nxt_period;
  logic [15:0] rdata_ff, nxt_rdata;
  logic        ack_ff, nxt_ack;
  logic        lock_ff, nxt_lock;
  logic [2:0]  hit;
  logic        cnt_clear;
  logic        period_end;
  logic        in_normal;
  logic [5:0]  limit;
  logic [5:0]  period_len;

  assign req_mode   = pmts_mode_t'(mode_s2_ff);
  assign in_normal  = (state_ff == PMTS_ST_NORMAL);
  assign limit      = {1'b0, level_ff[`PMTS_LEVEL_PERIOD_HI:`PMTS_LEVEL_PERIOD_LO]} + 6'h01;
  assign period_len = {1'b0, level_ff[`PMTS_LEVEL_PERIOD_HI:`PMTS_LEVEL_PERIOD_LO]}
                      + 6'(`PMTS_DEFAULT_EXTRA);
  assign period_end = (tick_ff == TICK_CYCLES - 32'h1) && (period_ff == period_len - 6'h01);
  // Counters run only while in tamper mode; cleared each default period
  assign cnt_clear  = (state_ff != PMTS_ST_TAMPER) || (!only_mode_ff && period_end);

  // Per-phase peak counters
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      pmts_phase_counter u_cnt (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .clk_en_in  (clk_en_in),
        .clear_in   (cnt_clear),
        .peak_in    (peak_s2_ff[g]),
        .limit_in   (limit),
        .hit_out    (hit[g])
      );
    end
  endgenerate

  // Mode sequencing, time base, registers and pin outcome
  always_comb begin
    nxt_state     = state_ff;
    nxt_level     = level_ff;
    nxt_cfg       = cfg_ff;
    nxt_only_mode = only_mode_ff;
    nxt_done_flag = done_flag_ff;
    nxt_l0        = l0_ff;
    nxt_l1        = l1_ff;
    nxt_result    = result_ff;
    nxt_swrst_cnt = swrst_cnt_ff;
    nxt_tick      = tick_ff;
    nxt_period    = period_ff;
    nxt_rdata     = rdata_ff;
    nxt_ack       = 1'b0;
    nxt_lock      = lock_ff;
    // Time base in clock cycles, restarts at each period boundary
    if (state_ff == PMTS_ST_TAMPER) begin
      if (tick_ff == TICK_CYCLES - 32'h1) begin
        nxt_tick = 32'h0;
        nxt_period = (period_ff == period_len - 6'h01) ? 6'h00 : period_ff + 6'h01;
      end else begin
        nxt_tick = tick_ff + 32'h1;
      end
    end else begin
      nxt_tick   = 32'h0;
      nxt_period = 6'h00;
    end
    unique case (state_ff)
      PMTS_ST_NORMAL: begin
        if (!hwr_s2_ff) begin
          nxt_level     = `PMTS_RST_TAMPER_LEVEL;
          nxt_cfg       = `PMTS_RST_LOW_POWER_CFG;
          nxt_lock      = 1'b0;
          nxt_done_flag = 1'b0;
          nxt_l1        = 1'b0;
          nxt_swrst_cnt = 5'h00;
          nxt_state     = PMTS_ST_RESET;
        end else if (sw_reset_in) begin
          nxt_done_flag = 1'b0;
          nxt_l1        = 1'b0;
          nxt_swrst_cnt = 5'h00;
          nxt_state     = PMTS_ST_RESET;
        end else if (req_mode == PMTS_MODE_REDUCED) begin
          nxt_state = PMTS_ST_REDUCED;
        end else if (req_mode == PMTS_MODE_TAMPER) begin
          nxt_state     = PMTS_ST_TAMPER;
          nxt_only_mode = cfg_ff[`PMTS_CFG_LINE_ZERO_DIS];
          nxt_l0        = 1'b0;
          nxt_l1        = 1'b0;
          nxt_result    = 1'b0;
        end else if (req_mode == PMTS_MODE_SLEEP) begin
          nxt_state = PMTS_ST_SLEEP;
        end
        // Register writes, only reachable in normal mode
        if (reg_wr_in && hwr_s2_ff && !sw_reset_in) begin
          nxt_ack = 1'b1;
          if (reg_addr_in == `PMTS_ADDR_TAMPER_LEVEL) begin
            nxt_level = reg_wdata_in[7:0];
          end else if (reg_addr_in == `PMTS_ADDR_LOW_POWER_CFG) begin
            nxt_cfg  = reg_wdata_in[7:0];
            nxt_lock = lock_ff | reg_wdata_in[`PMTS_CFG_PORT_LOCK];
          end else if (reg_addr_in == `PMTS_ADDR_STATUS_ONE) begin
            if (reg_wdata_in[`PMTS_STAT_RESET_DONE]) begin
              nxt_done_flag = 1'b0;
              nxt_l1        = 1'b0;
            end
          end
        end
      end
      PMTS_ST_RESET: begin
        if (swrst_cnt_ff == 5'(`PMTS_SWRST_CYCLES)) begin
          nxt_state     = PMTS_ST_NORMAL;
          nxt_done_flag = 1'b1;
          nxt_l1        = 1'b1;
        end else if (hwr_s2_ff) begin
          nxt_swrst_cnt = swrst_cnt_ff + 5'h01;
        end
      end
      PMTS_ST_REDUCED, PMTS_ST_TAMPER, PMTS_ST_SLEEP: begin
        // Tamper outcome: at period end in the default variant, at once on a hit in line-one-only mode
        if (state_ff == PMTS_ST_TAMPER) begin
          if (only_mode_ff) begin
            if (|hit) begin
              nxt_l1 = 1'b1;
            end
          end else if (period_end && !result_ff) begin
            nxt_result = 1'b1;
            if (|hit) begin
              nxt_l1 = 1'b1;
            end else begin
              nxt_l0 = 1'b1;
            end
          end
        end
        // Mode change requests; low-power registers kept
        if (req_mode == PMTS_MODE_NORMAL) begin
          nxt_state     = PMTS_ST_NORMAL;
          nxt_l0        = 1'b0;
          nxt_l1        = 1'b1;
          nxt_done_flag = 1'b1;
        end else if (req_mode == PMTS_MODE_REDUCED && state_ff != PMTS_ST_REDUCED) begin
          nxt_state = PMTS_ST_REDUCED;
          nxt_l0    = 1'b0;
          nxt_l1    = 1'b1;
        end else if (req_mode == PMTS_MODE_TAMPER && state_ff != PMTS_ST_TAMPER) begin
          nxt_state     = PMTS_ST_TAMPER;
          // Entry from normal or reduced can pick line-one-only; entry from sleep uses the default variant
          nxt_only_mode = (state_ff == PMTS_ST_SLEEP) ? 1'b0 : cfg_ff[`PMTS_CFG_LINE_ZERO_DIS];
          nxt_l0        = 1'b0;
          nxt_l1        = 1'b0;
          nxt_result    = 1'b0;
        end else if (req_mode == PMTS_MODE_SLEEP && state_ff != PMTS_ST_SLEEP) begin
          nxt_state = PMTS_ST_SLEEP;
          nxt_l0    = 1'b0;
          nxt_l1    = 1'b0;
        end
      end
      default: begin
        nxt_state = PMTS_ST_NORMAL;
      end
    endcase
    // Register reads: normal and reduced modes (reduced reads return zero); sleep and tamper ignore the port
    if (reg_rd_in && (in_normal || state_ff == PMTS_ST_REDUCED)) begin
      nxt_ack = 1'b1;
      if (reg_addr_in == `PMTS_ADDR_TAMPER_LEVEL && in_normal) begin
        nxt_rdata = {8'h00, level_ff};
      end else if (reg_addr_in == `PMTS_ADDR_LOW_POWER_CFG && in_normal) begin
        nxt_rdata = {8'h00, cfg_ff};
      end else if (reg_addr_in == `PMTS_ADDR_STATUS_ONE && in_normal) begin
        nxt_rdata = {done_flag_ff, 15'h0000};
      end else begin
        nxt_rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state_ff     <= PMTS_ST_NORMAL;
      level_ff     <= `PMTS_RST_TAMPER_LEVEL;
      cfg_ff       <= `PMTS_RST_LOW_POWER_CFG;
      only_mode_ff <= 1'b0;
      done_flag_ff <= 1'b0;
      l0_ff        <= 1'b0;
      l1_ff        <= 1'b0;
      result_ff    <= 1'b0;
      swrst_cnt_ff <= 5'h00;
      tick_ff      <= 32'h0;
      period_ff    <= 6'h00;
      rdata_ff     <= 16'h0000;
      ack_ff       <= 1'b0;
      lock_ff      <= 1'b0;
    end else if (clk_en_in) begin
      state_ff     <= nxt_state;
      level_ff     <= nxt_level;
      cfg_ff       <= nxt_cfg;
      only_mode_ff <= nxt_only_mode;
      done_flag_ff <= nxt_done_flag;
      l0_ff        <= nxt_l0;
      l1_ff        <= nxt_l1;
      result_ff    <= nxt_result;
      swrst_cnt_ff <= nxt_swrst_cnt;
      tick_ff      <= nxt_tick;
      period_ff    <= nxt_period;
      rdata_ff     <= nxt_rdata;
      ack_ff       <= nxt_ack;
      lock_ff      <= nxt_lock;
    end
  end

  // Outputs; line zero never asserted in line-one-only mode
  assign irq_line_zero_n_out = ~(l0_ff & ~only_mode_ff);
  assign irq_line_one_n_out  = ~l1_ff;
  assign reg_rdata_out       = rdata_ff;
  assign reg_ack_out         = ack_ff;
  assign power_mode_out      = (state_ff == PMTS_ST_REDUCED) ? 2'h1 :
                               (state_ff == PMTS_ST_TAMPER)  ? 2'h2 :
                               (state_ff == PMTS_ST_SLEEP)   ? 2'h3 : 2'h0;
  assign serial_port_en_out  = in_normal || (state_ff == PMTS_ST_REDUCED);
  assign serial_port_limited_out = (state_ff == PMTS_ST_REDUCED);
  assign port_lock_out       = lock_ff;
  assign mav_run_out         = (state_ff == PMTS_ST_REDUCED);
  assign mav_access_out      = in_normal || (state_ff == PMTS_ST_REDUCED && l1_ff) ||
                               (state_ff == PMTS_ST_REDUCED && !l1_ff);
  assign core_active_out     = (state_ff != PMTS_ST_SLEEP);
  assign tamper_threshold_select_out = level_ff[`PMTS_LEVEL_THRESH_HI:`PMTS_LEVEL_THRESH_LO];
  assign regs_default_out    = (state_ff == PMTS_ST_RESET);
endmodule

// *** core/pmts_map.svh ***
// Register map, field positions, reset values and timing counts for the power-mode tamper sequencer
`ifndef PMTS_MAP_SVH
`define PMTS_MAP_SVH
`define PMTS_ADDR_TAMPER_LEVEL   16'hEC00
`define PMTS_ADDR_LOW_POWER_CFG  16'hEC01
`define PMTS_ADDR_STATUS_ONE     16'hE503
`define PMTS_LEVEL_PERIOD_HI     7
`define PMTS_LEVEL_PERIOD_LO     3
`define PMTS_LEVEL_THRESH_HI     2
`define PMTS_LEVEL_THRESH_LO     0
`define PMTS_CFG_LINE_ZERO_DIS   2
`define PMTS_CFG_PORT_LOCK       1
`define PMTS_STAT_RESET_DONE     15
`define PMTS_RST_TAMPER_LEVEL    8'h00
`define PMTS_RST_LOW_POWER_CFG   8'h00
`define PMTS_CLK_HZ              200000000
`define PMTS_TICK_MS             20
`define PMTS_TICK_CYCLES         ((`PMTS_CLK_HZ / 1000) * `PMTS_TICK_MS)
`define PMTS_DEFAULT_EXTRA       10
`define PMTS_ONLY_EXTRA          1
`define PMTS_SWRST_CYCLES        16
`endif

// *** core/pmts_pkg.sv ***
// Types shared by the power-mode tamper sequencer
package pmts_pkg;
  typedef enum logic [1:0] {
    PMTS_MODE_NORMAL  = 2'h0,
    PMTS_MODE_REDUCED = 2'h1,
    PMTS_MODE_TAMPER  = 2'h2,
    PMTS_MODE_SLEEP   = 2'h3
  } pmts_mode_t;
  typedef enum logic [4:0] {
    PMTS_ST_NORMAL  = 5'h01,
    PMTS_ST_RESET   = 5'h02,
    PMTS_ST_REDUCED = 5'h04,
    PMTS_ST_TAMPER  = 5'h08,
    PMTS_ST_SLEEP   = 5'h10
  } pmts_state_t;
endpackage

// *** core/pmts_phase_counter.sv ***
// One phase peak counter with rising-edge detect and hit compare
`timescale 1ns/1ps
module pmts_phase_counter
  import pmts_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       clk_en_in,
  input  wire logic       clear_in,
  input  wire logic       peak_in,
  input  wire logic [5:0] limit_in,
  output logic            hit_out
);
  logic [6:0] count_ff;
  logic [6:0] nxt_count;
  logic       prev_ff;
  logic       nxt_prev;

  // Count each new excursion above threshold, saturating
  always_comb begin
    nxt_prev  = peak_in;
    nxt_count = count_ff;
    if (clear_in) begin
      nxt_count = 7'h00;
    end else if (peak_in && !prev_ff && count_ff != 7'h7F) begin
      nxt_count = count_ff + 7'h01;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      count_ff <= 7'h00;
      prev_ff  <= 1'b0;
    end else if (clk_en_in) begin
      count_ff <= nxt_count;
      prev_ff  <= nxt_prev;
    end
  end

  // Reached period count plus one
  assign hit_out = (count_ff >= {1'b0, limit_in});
endmodule

// *** sim/pmts_seq_chk.sv ***
// Port assertions for the power-mode tamper sequencer
`timescale 1ns/1ps
module pmts_seq_chk
  import pmts_pkg::*;
(
  input wire logic       mclk_in,
  input wire logic       sys_rst_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic       reg_ack_out,
  input wire logic       irq_line_zero_n_out,
  input wire logic       irq_line_one_n_out,
  input wire logic [1:0] power_mode_out,
  input wire logic       serial_port_en_out,
  input wire logic       serial_port_limited_out,
  input wire logic       mav_run_out,
  input wire logic       core_active_out,
  input wire logic [2:0] tamper_threshold_select_out,
  input wire logic       regs_default_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // Mode-dependent pins and refused accesses
  zero_tamper_a: assert property (power_mode_out != 2'h2 && $past(power_mode_out) != 2'h2
    |-> irq_line_zero_n_out)
    else $error("line zero low outside tamper mode");
  port_off_a: assert property (power_mode_out[1] |-> !serial_port_en_out)
    else $error("serial port on in tamper or sleep");
  limited_a: assert property (power_mode_out == 2'h1 |-> serial_port_limited_out)
    else $error("port not limited in reduced mode");
  mav_start_a: assert property ($past(power_mode_out) == 2'h0 && power_mode_out == 2'h1 |-> mav_run_out)
    else $error("averaging not started at once");
  core_sleep_a: assert property (power_mode_out == 2'h3 |-> !core_active_out)
    else $error("core active in sleep");
  wr_refuse_a: assert property (reg_wr_in && !reg_rd_in && power_mode_out != 2'h0 |=> !reg_ack_out)
    else $error("write acknowledged outside normal mode");
  rd_refuse_a: assert property (reg_rd_in && power_mode_out[1] |=> !reg_ack_out)
    else $error("read acknowledged in tamper or sleep");
  thresh_keep_a: assert property (power_mode_out != 2'h0 && $past(power_mode_out) != 2'h0
    |-> $stable(tamper_threshold_select_out))
    else $error("threshold changed in low power");
  done_irq_a: assert property ($fell(regs_default_out) && !$past(sys_rst_in)
    |-> ##[0:2] !irq_line_one_n_out)
    else $error("line one not low after transition");
endmodule
bind pmts_sequencer pmts_seq_chk i_chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_ack_out(reg_ack_out),
  .irq_line_zero_n_out(irq_line_zero_n_out), .irq_line_one_n_out(irq_line_one_n_out),
  .power_mode_out(power_mode_out), .serial_port_en_out(serial_port_en_out),
  .serial_port_limited_out(serial_port_limited_out), .mav_run_out(mav_run_out),
  .core_active_out(core_active_out), .tamper_threshold_select_out(tamper_threshold_select_out),
  .regs_default_out(regs_default_out));

// *** sim/pmts_host_model.sv ***
// Host model that watches the interrupt pins and times each mode stay
`timescale 1ns/1ps
module pmts_host_model (
  input  wire logic        mclk_in,
  input  wire logic        restart_in,
  input  wire logic        irq_line_zero_n_in,
  input  wire logic        irq_line_one_n_in,
  output logic             zero_seen_out,
  output logic             one_seen_out,
  output logic [31:0]      wait_cycles_out
);
  // Latch pin lows and run the host's own timer per mode request
  always_ff @(posedge mclk_in) begin
    if (restart_in) begin
      zero_seen_out   <= 1'b0;
      one_seen_out    <= 1'b0;
      wait_cycles_out <= 32'h0;
    end else begin
      zero_seen_out   <= zero_seen_out | ~irq_line_zero_n_in;
      one_seen_out    <= one_seen_out | ~irq_line_one_n_in;
      wait_cycles_out <= wait_cycles_out + 32'h1;
    end
  end
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the power-mode tamper sequencer
`timescale 1ns/1ps
`include "pmts_map.svh"
module tb_top;
  logic        mclk_in       = 1'b0;
  logic        sys_rst_in    = 1'b1;
  logic [1:0]  mode_pins_in  = 2'h0;
  logic        hw_reset_n_in = 1'b1; // Held high in sleep
  logic        sw_reset_in   = 1'b0;
  logic [2:0]  phase_peak_in = 3'h0;
  logic        reg_wr_in     = 1'b0;
  logic        reg_rd_in     = 1'b0;
  logic [15:0] reg_addr_in   = 16'h0;
  logic [15:0] reg_wdata_in  = 16'h0;
  logic        host_clr      = 1'b1;
  logic [15:0] reg_rdata_out;
  logic [1:0]  power_mode_out;
  logic [2:0]  tamper_threshold_select_out;
  logic        reg_ack_out, irq_line_zero_n_out, irq_line_one_n_out, serial_port_en_out;
  logic        serial_port_limited_out, port_lock_out, mav_run_out, mav_access_out;
  logic        core_active_out, regs_default_out, zero_seen, one_seen;
  logic        clk_en_in = 1'b1;
  logic [31:0] host_wait;
  localparam logic [15:0] RUN_ADDR = 16'hE000; // Run register address, arbitrary value
  logic [15:0] rd;
  logic        ak;
  int          errors = 0;
  int          tests_run = 0;
  always #2.5 mclk_in = ~mclk_in;
  pmts_sequencer i_dut (.mclk_in, .sys_rst_in, .clk_en_in, .mode_pins_in, .hw_reset_n_in,
    .sw_reset_in, .phase_peak_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
    .reg_rdata_out, .reg_ack_out, .irq_line_zero_n_out, .irq_line_one_n_out, .power_mode_out,
    .serial_port_en_out, .serial_port_limited_out, .port_lock_out, .mav_run_out, .mav_access_out,
    .core_active_out, .tamper_threshold_select_out, .regs_default_out);
  pmts_host_model i_host (.mclk_in, .restart_in(host_clr), .irq_line_zero_n_in(irq_line_zero_n_out),
    .irq_line_one_n_in(irq_line_one_n_out), .zero_seen_out(zero_seen), .one_seen_out(one_seen),
    .wait_cycles_out(host_wait));
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One register access; ack and data sampled after the answer edge
  task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    reg_wr_in    <= wr;
    reg_rd_in    <= !wr;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    #1;
    ak = reg_ack_out;
    rd = reg_rdata_out;
  endtask
  // Bounded wait for line one low
  task automatic wait_one(input int lim);
    int n;
    n = 0;
    while (irq_line_one_n_out !== 1'b0 && n < lim) begin
      @(posedge mclk_in);
      n++;
    end
    #1;
  endtask
  // Request a mode and wait for it
  task automatic go(input logic [1:0] m);
    int n;
    n = 0;
    @(posedge mclk_in);
    mode_pins_in <= m;
    host_clr     <= 1'b1;
    @(posedge mclk_in);
    host_clr <= 1'b0;
    while (power_mode_out !== m && n < 50) begin
      @(posedge mclk_in);
      n++;
    end
    #1;
    chk(power_mode_out, m);
  endtask
  // Phase A comparator pulses
  task automatic peaks(input int cnt);
    repeat (cnt) begin
      @(posedge mclk_in);
      phase_peak_in <= 3'h1;
      repeat (4) @(posedge mclk_in);
      phase_peak_in <= 3'h0;
      repeat (4) @(posedge mclk_in);
    end
    repeat (6) @(posedge mclk_in);
    #1;
  endtask
  // Counts and verdict
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #100000;
    errors++;
    wrap_up();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    #1;
    chk(16'({irq_line_zero_n_out, irq_line_one_n_out, serial_port_en_out}), 16'h7);
    acc(1'b0, `PMTS_ADDR_LOW_POWER_CFG, 16'h0);
    chk(rd, 16'h0);
    acc(1'b1, `PMTS_ADDR_TAMPER_LEVEL, 16'h002B);
    acc(1'b1, `PMTS_ADDR_LOW_POWER_CFG, 16'h0006);
    // Frozen clock enable: a write must not land
    @(posedge mclk_in);
    clk_en_in <= 1'b0;
    acc(1'b1, `PMTS_ADDR_TAMPER_LEVEL, 16'h00FF);
    chk(16'(ak), 16'h0);
    @(posedge mclk_in);
    clk_en_in <= 1'b1;
    acc(1'b0, `PMTS_ADDR_TAMPER_LEVEL, 16'h0);
    chk(rd, 16'h002B);
    chk(16'(tamper_threshold_select_out), 16'h3);
    acc(1'b0, 16'h1234, 16'h0);
    chk({ak, rd[14:0]}, 16'h8000);
    // Software reset keeps low-power settings and lock
    @(posedge mclk_in);
    sw_reset_in <= 1'b1;
    @(posedge mclk_in);
    sw_reset_in <= 1'b0;
    wait_one(200);
    chk(16'(irq_line_one_n_out), 16'h0);
    acc(1'b0, `PMTS_ADDR_STATUS_ONE, 16'h0);
    chk(rd, 16'h8000);
    acc(1'b0, `PMTS_ADDR_LOW_POWER_CFG, 16'h0);
    chk({port_lock_out, rd[14:0]}, 16'h8006);
    // Host preparation before leaving normal: stop processor, erase flags
    acc(1'b1, RUN_ADDR, 16'h0000);
    chk(16'(ak), 16'h1);
    acc(1'b1, `PMTS_ADDR_STATUS_ONE, 16'h8000);
    chk(16'(irq_line_one_n_out), 16'h1);
    // Line-one-only tamper: five crossings stay quiet, the sixth fires
    go(2'h2);
    chk(16'({serial_port_en_out, tamper_threshold_select_out}), 16'h3);
    acc(1'b1, `PMTS_ADDR_LOW_POWER_CFG, 16'h0);
    chk(16'(ak), 16'h0);
    peaks(5);
    chk(16'({zero_seen, one_seen}), 16'h0);
    peaks(1);
    chk(16'({zero_seen, irq_line_one_n_out}), 16'h0);
    chk(16'(host_wait > 32'd60), 16'h1);
    // Sleep, then tamper again in the default variant
    go(2'h3);
    acc(1'b0, `PMTS_ADDR_TAMPER_LEVEL, 16'h0);
    chk(16'({core_active_out, ak}), 16'h0);
    go(2'h2);
    peaks(8);
    chk(16'({irq_line_zero_n_out, irq_line_one_n_out}), 16'h3);
    // Reduced entry from tamper
    go(2'h1);
    wait_one(200);
    chk(16'({irq_line_one_n_out, mav_run_out, mav_access_out}), 16'h3);
    acc(1'b0, `PMTS_ADDR_TAMPER_LEVEL, 16'h0);
    chk(16'(ak), 16'h1);
    chk(rd, 16'h0);
    // Back to normal: host polls the done flag
    go(2'h0);
    rd = 16'h0;
    for (int i = 0; i < 100 && rd[15] !== 1'b1; i++) begin
      acc(1'b0, `PMTS_ADDR_STATUS_ONE, 16'h0);
    end
    chk(rd, 16'h8000);
    chk(16'(irq_line_one_n_out), 16'h0);
    acc(1'b0, `PMTS_ADDR_TAMPER_LEVEL, 16'h0);
    chk(rd, 16'h002B);
    acc(1'b1, `PMTS_ADDR_STATUS_ONE, 16'h8000);
    // Hardware reset pin restores low-power settings and lock to reset values
    @(posedge mclk_in);
    hw_reset_n_in <= 1'b0;
    repeat (8) @(posedge mclk_in);
    hw_reset_n_in <= 1'b1;
    wait_one(200);
    chk(16'(irq_line_one_n_out), 16'h0);
    acc(1'b0, `PMTS_ADDR_LOW_POWER_CFG, 16'h0);
    chk({port_lock_out, rd[14:0]}, 16'h0);
    acc(1'b0, `PMTS_ADDR_TAMPER_LEVEL, 16'h0);
    chk(rd, 16'h0);
    wrap_up();
  end
endmodule
